// File: core/udd_unit.sv
// Unsigned word divide and difference-or-zero execution unit
//
// Contract
// - Divide writes the unsigned quotient of first by second source.
// - A zero divisor leaves an arbitrary value in the target.
// - With record set, divide judges the quotient as signed for cr0.
// - With range check set, overflow and summary overflow update.
// - With record set, cr0 takes lt, gt, zero and summary copy.
// - Divide has four variants from the range check and record bits.
// - No divide variant touches the ripple out flag.
// - Difference-or-zero forms not first plus one plus second.
// - If first is signed greater than second, the result is zero.
// - Difference overflow flags only a positive overflow.
// - Difference never touches ripple out; same four variants.
// - One target and two sources; first is dividend, second divisor.
`timescale 1ns/100ps
`default_nettype none
module udd_unit
    import udd_pkg::*;
#(
    parameter int XLEN = UDD_XLEN
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Issue from the decoder
    input  wire logic                  issue_valid,
    output logic                       issue_ready,
    input  wire logic [31:0]           instr_word,
    input  wire logic [XLEN-1:0]       first_source_value,
    input  wire logic [XLEN-1:0]       second_source_value,
    // Result back to the register file
    output logic                       wb_valid,
    output logic [UDD_GPR_W-1:0]       target_gpr,
    output logic [XLEN-1:0]            wb_data,
    // Exception and condition flags
    output logic                       ripple_out_flag,
    output logic                       result_out_of_range_flag,
    output logic                       summary_overflow_flag,
    output logic                       less_than_flag,
    output logic                       greater_than_flag,
    output logic                       zero_result_flag,
    output logic                       cr0_summary_flag,
    // AXI4-Lite slave
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [UDD_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [UDD_AXI_AW-1:0] s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // Interrupt
    output logic                       irq
);
    // Signed judgement of a result into lt, gt, zero and summary copy
    function automatic logic [3:0] udd_cr0_judge(
        input logic [XLEN-1:0] v,
        input logic            so
    );
        udd_cr0_judge = {v[XLEN-1], !v[XLEN-1] && (v != '0), v == '0, so};
    endfunction : udd_cr0_judge

    // Offsets that answer OKAY on the bus; any other offset gets SLVERR
    function automatic logic udd_reg_known(input logic [UDD_AXI_AW-1:0] a);
        udd_reg_known = (a == UDD_EXC_OFS) || (a == UDD_CR0_OFS) ||
                        (a == UDD_ISTS_OFS) || (a == UDD_IMASK_OFS);
    endfunction : udd_reg_known

    udd_state_t               state_reg;
    logic [UDD_GPR_W-1:0]     tgt_reg;
    logic                     oe_reg;
    logic                     rc_reg;
    logic                     isdiv_reg;
    logic                     ovf_reg;
    logic                     dz_reg;
    logic [XLEN-1:0]          res_reg;
    logic [XLEN-1:0]          opa_reg;
    logic [XLEN-1:0]          opb_reg;
    logic [UDD_EXC_W-1:0]     exc_reg;
    logic [UDD_CR0_W-1:0]     cr0_reg;
    logic [UDD_NEV-1:0]       ists_reg;
    logic [UDD_NEV-1:0]       imask_reg;
    logic [UDD_NEV-1:0]       ev;
    logic                     aw_got_reg;
    logic                     w_got_reg;
    logic [UDD_AXI_AW-1:0]    awaddr_reg;
    logic [UDD_EXC_W-1:0]     wdata_reg;
    logic [UDD_NEV-1:0]       wmask_reg;
    logic                     wlane_reg;
    logic                     bvalid_reg;
    logic [1:0]               bresp_reg;
    logic                     rvalid_reg;
    logic [31:0]              rdata_reg;
    logic [1:0]               rresp_reg;
    logic [31:0]              rd_word;

    udd_div_if #(.WIDTH(XLEN)) div_bus ();

    udd_divider #(
        .WIDTH   (XLEN)
    ) u_divider (
        .aclk    (aclk),
        .aresetn (aresetn),
        .div     (div_bus.srv)
    );

    // Instruction field decode
    wire logic [5:0] opc      = instr_word[UDD_OPC_LSB +: 6];
    wire logic [8:0] xo       = instr_word[UDD_XO_LSB +: 9];
    wire logic is_primary     = (opc == UDD_PRIMARY_OP);
    wire logic is_divu        = is_primary && (xo == UDD_XO_DIVU);
    wire logic is_doz         = is_primary && (xo == UDD_XO_DOZ);
    wire logic op_ok          = is_divu || is_doz;
    wire logic issue_fire     = issue_valid && issue_ready;
    wire logic divisor_zero   = (second_source_value == '0);

    // Difference-or-zero datapath, finished in the issue cycle
    wire logic [XLEN-1:0] doz_diff =
        ~first_source_value + second_source_value + XLEN'(1);
    wire logic doz_gt =
        $signed(first_source_value) > $signed(second_source_value);
    wire logic [XLEN-1:0] doz_res = doz_gt ? '0 : doz_diff;
    // Only a negative first and non-negative second can wrap upward
    wire logic doz_ovf = !second_source_value[XLEN-1] &&
                         first_source_value[XLEN-1] &&
                         doz_diff[XLEN-1];

    // Divider request straight from the issue operands
    assign div_bus.start    = issue_fire && is_divu;
    assign div_bus.dividend = first_source_value;
    assign div_bus.divisor  = second_source_value;

    // Handshake and writeback outputs
    assign issue_ready = (state_reg == UDD_S_IDLE);
    assign wb_valid    = (state_reg == UDD_S_WB);
    assign target_gpr  = tgt_reg;
    assign wb_data     = res_reg;

    // Sequencer; unknown instructions are accepted and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= UDD_S_IDLE;
        end else begin
            case (state_reg)
                UDD_S_IDLE: begin
                    if (issue_fire && op_ok) begin
                        state_reg <= is_divu ? UDD_S_DIV : UDD_S_WB;
                    end
                end
                UDD_S_DIV: begin
                    if (div_bus.done) begin
                        state_reg <= UDD_S_WB;
                    end
                end
                UDD_S_WB:  state_reg <= UDD_S_IDLE;
                default:   state_reg <= UDD_S_IDLE;
            endcase
        end
    end

    // Capture of the operation and its result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tgt_reg   <= '0;
            oe_reg    <= 1'h0;
            rc_reg    <= 1'h0;
            isdiv_reg <= 1'h0;
            ovf_reg   <= 1'h0;
            dz_reg    <= 1'h0;
            res_reg   <= '0;
            opa_reg   <= '0;
            opb_reg   <= '0;
        end else if (issue_fire && op_ok) begin
            tgt_reg   <= instr_word[UDD_TGT_LSB +: UDD_GPR_W];
            oe_reg    <= instr_word[UDD_OE_BIT];
            rc_reg    <= instr_word[UDD_RC_BIT];
            isdiv_reg <= is_divu;
            // A zero divisor counts as the divide's overflow
            ovf_reg   <= is_divu ? divisor_zero : doz_ovf;
            dz_reg    <= is_divu && divisor_zero;
            res_reg   <= doz_res;
            opa_reg   <= first_source_value;
            opb_reg   <= second_source_value;
        end else if (state_reg == UDD_S_DIV && div_bus.done) begin
            res_reg   <= div_bus.quotient;
        end
    end

    // Flag update terms
    wire logic ovf_hit = wb_valid && oe_reg && ovf_reg;
    wire logic so_next = exc_reg[UDD_SO_BIT] || ovf_hit;
    wire logic wr_go   = aw_got_reg && w_got_reg && !bvalid_reg;
    wire logic exc_wr_en =
        wr_go && wlane_reg && (awaddr_reg == UDD_EXC_OFS);
    wire logic imask_wr_en =
        wr_go && wlane_reg && (awaddr_reg == UDD_IMASK_OFS);

    // Exception register; hardware update wins over a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exc_reg <= UDD_EXC_RST;
        end else begin
            if (exc_wr_en) begin
                exc_reg <= wdata_reg;
            end
            if (wb_valid && oe_reg) begin
                exc_reg[UDD_OV_BIT] <= ovf_reg;
                exc_reg[UDD_SO_BIT] <= so_next;
            end
        end
    end

    // Condition field 0, written only by recording variants
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cr0_reg <= UDD_CR0_RST;
        end else if (wb_valid && rc_reg) begin
            cr0_reg <= udd_cr0_judge(res_reg, so_next);
        end
    end

    // Ripple out is only ever software's; no operation writes it
    assign ripple_out_flag          = exc_reg[UDD_CA_BIT];
    assign result_out_of_range_flag = exc_reg[UDD_OV_BIT];
    assign summary_overflow_flag    = exc_reg[UDD_SO_BIT];
    assign less_than_flag           = cr0_reg[3];
    assign greater_than_flag        = cr0_reg[2];
    assign zero_result_flag         = cr0_reg[1];
    assign cr0_summary_flag         = cr0_reg[0];

    // Interrupt events
    assign ev[UDD_EV_OVF]   = ovf_hit;
    assign ev[UDD_EV_DZERO] = wb_valid && isdiv_reg && dz_reg;
    assign ev[UDD_EV_UNSUP] = issue_fire && !op_ok;
    assign ev[UDD_EV_DONE]  = wb_valid;

    wire logic ar_fire  = s_axi_arvalid && s_axi_arready;
    wire logic ists_clr = ar_fire && (s_axi_araddr == UDD_ISTS_OFS);

    // Sticky status, read clears, a new event in that cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ists_reg  <= '0;
            imask_reg <= UDD_IMASK_RST;
        end else begin
            ists_reg <= (ists_clr ? '0 : ists_reg) | ev;
            if (imask_wr_en) begin
                imask_reg <= wmask_reg;
            end
        end
    end

    assign irq = |(ists_reg & imask_reg);

    // Write channels, address and data taken in either order
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // Capture of write address, write data and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'h0;
            w_got_reg  <= 1'h0;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wmask_reg  <= '0;
            wlane_reg  <= 1'h0;
            bvalid_reg <= 1'h0;
            bresp_reg  <= UDD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'h1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'h1;
                wdata_reg <= s_axi_wdata[UDD_EXC_W-1:0];
                wmask_reg <= s_axi_wdata[UDD_NEV-1:0];
                // Fields sit in the low byte, other lanes are dropped
                wlane_reg <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_got_reg <= 1'h0;
                w_got_reg  <= 1'h0;
                bvalid_reg <= 1'h1;
                bresp_reg  <= udd_reg_known(awaddr_reg) ?
                              UDD_RESP_OKAY : UDD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'h0;
            end
        end
    end

    // Read word selection
    always_comb begin
        case (s_axi_araddr)
            UDD_EXC_OFS:   rd_word = {29'h0, exc_reg};
            UDD_CR0_OFS:   rd_word = {28'h0, cr0_reg};
            UDD_ISTS_OFS:  rd_word = {28'h0, ists_reg};
            UDD_IMASK_OFS: rd_word = {28'h0, imask_reg};
            default:       rd_word = 32'h0;
        endcase
    end

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Read answer held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'h0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= UDD_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'h1;
            rdata_reg  <= rd_word;
            rresp_reg  <= udd_reg_known(s_axi_araddr) ?
                          UDD_RESP_OKAY : UDD_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'h0;
        end
    end

    // Quotient matches the latched operands whenever it is defined
    property p_div_quot;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && isdiv_reg && opb_reg != '0) |->
            wb_data == opa_reg / opb_reg;
    endproperty
    a_div_quot: assert property (p_div_quot)
        else $error("quotient wrong");

    property p_cr0_signed;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && rc_reg) |=> (less_than_flag == res_reg[XLEN-1]) &&
            (zero_result_flag == (res_reg == '0)) &&
            (cr0_summary_flag == summary_overflow_flag);
    endproperty
    a_cr0_signed: assert property (p_cr0_signed)
        else $error("cr0 not judged as signed");

    property p_cr0_hold;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && !rc_reg) |=> $stable(cr0_reg);
    endproperty
    a_cr0_hold: assert property (p_cr0_hold)
        else $error("cr0 changed without record");

    property p_ov_hold;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && !oe_reg && !exc_wr_en) |=> $stable(exc_reg);
    endproperty
    a_ov_hold: assert property (p_ov_hold)
        else $error("overflow flags changed without range check");

    property p_ov_set;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && oe_reg && ovf_reg) |=>
            result_out_of_range_flag && summary_overflow_flag;
    endproperty
    a_ov_set: assert property (p_ov_set)
        else $error("overflow not recorded");

    property p_ca_stable;
        @(posedge aclk) disable iff (!aresetn)
        !exc_wr_en |=> $stable(ripple_out_flag);
    endproperty
    a_ca_stable: assert property (p_ca_stable)
        else $error("ripple out changed by an operation");

    property p_doz_zero;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && !isdiv_reg && $signed(opa_reg) > $signed(opb_reg))
            |-> wb_data == '0;
    endproperty
    a_doz_zero: assert property (p_doz_zero)
        else $error("difference not clamped to zero");

    property p_doz_diff;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && !isdiv_reg && $signed(opa_reg) <= $signed(opb_reg))
            |-> wb_data == XLEN'(opb_reg - opa_reg);
    endproperty
    a_doz_diff: assert property (p_doz_diff)
        else $error("difference wrong");

    property p_doz_ovf;
        @(posedge aclk) disable iff (!aresetn)
        (wb_valid && !isdiv_reg) |-> ovf_reg == (!opb_reg[XLEN-1] &&
            opa_reg[XLEN-1] && wb_data[XLEN-1]);
    endproperty
    a_doz_ovf: assert property (p_doz_ovf)
        else $error("difference overflow misjudged");

    property p_unsup_drop;
        @(posedge aclk) disable iff (!aresetn)
        (issue_fire && !op_ok) |=> issue_ready && !wb_valid;
    endproperty
    a_unsup_drop: assert property (p_unsup_drop)
        else $error("unknown instruction executed");

endmodule : udd_unit
`default_nettype wire

// File: core/udd_pkg.sv
// Shared constants and types of the divide and difference unit
`default_nettype none
package udd_pkg;
    // Datapath and bus widths
    localparam int UDD_XLEN   = 32;
    localparam int UDD_GPR_W  = 5;
    localparam int UDD_AXI_AW = 8;
    // Instruction layout, bit 0 of the word is the record bit
    localparam logic [5:0] UDD_PRIMARY_OP = 6'h1f;
    localparam logic [8:0] UDD_XO_DIVU    = 9'h1cb;
    localparam logic [8:0] UDD_XO_DOZ     = 9'h108;
    localparam int UDD_OPC_LSB  = 26;
    localparam int UDD_TGT_LSB  = 21;
    localparam int UDD_OE_BIT   = 10;
    localparam int UDD_XO_LSB   = 1;
    localparam int UDD_RC_BIT   = 0;
    // Register offsets
    localparam logic [7:0] UDD_EXC_OFS   = 8'h00;
    localparam logic [7:0] UDD_CR0_OFS   = 8'h04;
    localparam logic [7:0] UDD_ISTS_OFS  = 8'h08;
    localparam logic [7:0] UDD_IMASK_OFS = 8'h0c;
    // Exception register fields
    localparam int UDD_EXC_W  = 3;
    localparam int UDD_CA_BIT = 0;
    localparam int UDD_OV_BIT = 1;
    localparam int UDD_SO_BIT = 2;
    // Condition field 0 fields
    localparam int UDD_CR0_W = 4;
    // Interrupt event bits
    localparam int UDD_NEV      = 4;
    localparam int UDD_EV_OVF   = 0;
    localparam int UDD_EV_DZERO = 1;
    localparam int UDD_EV_UNSUP = 2;
    localparam int UDD_EV_DONE  = 3;
    // Reset values
    localparam logic [2:0] UDD_EXC_RST   = 3'h0;
    localparam logic [3:0] UDD_CR0_RST   = 4'h0;
    localparam logic [3:0] UDD_IMASK_RST = 4'h0;
    // Bus responses
    localparam logic [1:0] UDD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] UDD_RESP_SLVERR = 2'h2;
    // Sequencer states
    typedef enum logic [2:0] {
        UDD_S_IDLE = 3'h1,
        UDD_S_DIV  = 3'h2,
        UDD_S_WB   = 3'h4
    } udd_state_t;
endpackage : udd_pkg
`default_nettype wire

// File: core/udd_div_if.sv
// Request and answer bundle between sequencer and divider
`timescale 1ns/100ps
`default_nettype none
interface udd_div_if #(
    parameter int WIDTH = 32
);
    logic             start;
    logic [WIDTH-1:0] dividend;
    logic [WIDTH-1:0] divisor;
    logic [WIDTH-1:0] quotient;
    logic             done;
    modport req (output start, dividend, divisor, input quotient, done);
    modport srv (input start, dividend, divisor, output quotient, done);
endinterface : udd_div_if
`default_nettype wire

// File: core/udd_divider.sv
// Iterative restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/100ps
`default_nettype none
module udd_divider
    import udd_pkg::*;
#(
    parameter int WIDTH = UDD_XLEN
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Divide request and answer
    udd_div_if.srv   div
);
    localparam int CNT_W = $clog2(WIDTH + 1);

    logic [WIDTH:0]   rem_reg;
    logic [WIDTH-1:0] quo_reg;
    logic [WIDTH-1:0] dvs_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic             busy_reg;
    logic             done_reg;

    // Trial subtraction; a zero divisor always fits, giving all ones
    wire logic [WIDTH:0] shifted = {rem_reg[WIDTH-1:0], quo_reg[WIDTH-1]};
    wire logic [WIDTH:0] trial   = shifted - {1'h0, dvs_reg};
    wire logic           fits    = !trial[WIDTH];
    wire logic           last    = (cnt_reg == CNT_W'(1));

    // Operands are latched so the requester may change them after start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rem_reg  <= '0;
            quo_reg  <= '0;
            dvs_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'h0;
            done_reg <= 1'h0;
        end else begin
            done_reg <= busy_reg && last;
            if (div.start) begin
                rem_reg  <= '0;
                quo_reg  <= div.dividend;
                dvs_reg  <= div.divisor;
                cnt_reg  <= CNT_W'(WIDTH);
                busy_reg <= 1'h1;
            end else if (busy_reg) begin
                rem_reg  <= fits ? trial : shifted;
                quo_reg  <= {quo_reg[WIDTH-2:0], fits};
                cnt_reg  <= cnt_reg - CNT_W'(1);
                busy_reg <= !last;
            end
        end
    end

    assign div.quotient = quo_reg;
    assign div.done     = done_reg;

    // Answer comes a fixed 33 edges after start for the 32-bit build
    property p_div_latency;
        @(posedge aclk) disable iff (!aresetn)
        div.start |-> ##33 div.done;
    endproperty
    a_div_latency: assert property (p_div_latency)
        else $error("divider answer not on time");

endmodule : udd_divider
`default_nettype wire

// File: core/udd_unit_fix.sv
// Spare source unit, intentionally holds no logic
`default_nettype none
`default_nettype wire

// File: verification/udd_dec_model.sv
// Decoder and register file stand-in on the issue port
`timescale 1ns/100ps
`default_nettype none
module udd_dec_model (
    // Clock and bench request
    input  wire logic        aclk,
    input  wire logic        go,
    input  wire logic [95:0] req,
    // Issue port of the unit
    input  wire logic        issue_ready,
    output logic             issue_valid = 1'b0,
    output logic [31:0]      instr_word = 32'h0,
    output logic [31:0]      first_source_value = 32'h0,
    output logic [31:0]      second_source_value = 32'h0
);
    // Offer held until taken; operands scrambled after, never stale
    always @(posedge aclk) begin
        if (issue_valid && issue_ready) begin
            issue_valid <= 1'b0;
            first_source_value <= ~first_source_value;
            second_source_value <= ~second_source_value;
        end else if (go) begin
            issue_valid <= 1'b1;
            {instr_word, first_source_value, second_source_value} <= req;
        end
    end
endmodule : udd_dec_model
`default_nettype wire

// File: verification/test_unsigned_divide_and_difference_unit.sv
// Self-checking bench of the divide and difference unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module test_unsigned_divide_and_difference_unit
    import udd_pkg::*;
;
    logic aclk = 0, aresetn = 0, go = 0, awv = 0, wv = 0, brd = 0;
    logic arv = 0, rrd = 0, iv, ir, wbv, ca, ov, so, lt, gt, eq, cs, irq;
    logic awr, wr, bv, arr, rv, e_ov = 0, e_so = 0, cv = 0;
    logic [1:0] br, rr;
    logic [3:0] cr = 0;
    logic [4:0] tg;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, iw, fa, sb, wbd, rd, a, rs = 32'h18;
    logic [95:0] req = 0;
    int n_errors = 0, comparisons = 0;
    always #12.5 aclk = ~aclk;
    udd_dec_model dec_u (.aclk(aclk), .go(go), .req(req), .issue_ready(ir),
        .issue_valid(iv), .instr_word(iw), .first_source_value(fa),
        .second_source_value(sb));
    udd_unit dut_u (.aclk(aclk), .aresetn(aresetn), .issue_valid(iv),
        .issue_ready(ir), .instr_word(iw), .first_source_value(fa),
        .second_source_value(sb), .wb_valid(wbv), .target_gpr(tg),
        .wb_data(wbd), .ripple_out_flag(ca), .result_out_of_range_flag(ov),
        .summary_overflow_flag(so), .less_than_flag(lt),
        .greater_than_flag(gt), .zero_result_flag(eq), .cr0_summary_flag(cs),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrd),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .irq(irq));
    // Pseudo-random source, fixed start value keeps runs repeatable
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic stop_test();
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // Each channel released at its own handshake edge
    task automatic axw(input logic [7:0] ad, input logic [31:0] d,
                       input logic [1:0] er);
        @(posedge aclk);
        {awv, wv, brd, awa, wd} <= {3'h7, ad, d};
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        brd <= 1'b0;
        `CHK(br, er)
    endtask : axw
    task automatic axr(input logic [7:0] ad, input logic [31:0] m, e,
                       input logic [1:0] er);
        @(posedge aclk);
        {arv, rrd, ara} <= {2'h3, ad};
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rrd <= 1'b0;
        `CHK({rd & m, rr}, {e, er})
    endtask : axr
    // One instruction; result, target and flags against own reckoning
    task automatic run(input logic [8:0] xo, input logic oe, rc,
                       input logic [31:0] x, y);
        logic [32:0] d;
        logic [31:0] r;
        logic v, dz;
        logic [4:0] t;
        int k;
        t = x[4:0] ^ y[9:5];
        d = {y[31], y} - {x[31], x};
        dz = (xo == UDD_XO_DIVU) && (y == 32'h0);
        if (xo == UDD_XO_DIVU) begin
            r = dz ? 32'h0 : x / y;
            v = dz;
        end else begin
            r = ($signed(x) > $signed(y)) ? 32'h0 : d[31:0];
            v = !d[32] && d[31];
        end
        @(posedge aclk);
        go <= 1'b1;
        req <= {UDD_PRIMARY_OP, t, 10'h0, oe, xo, rc, x, y};
        @(posedge aclk);
        go <= 1'b0;
        k = 0;
        do begin
            @(negedge aclk);
            k++;
        end while (wbv !== 1'b1 && k < 60);
        `CHK(wbv, 1'b1)
        `CHK(tg, t)
        if (!dz) `CHK(wbd, r)
        if (oe) {e_ov, e_so} = {v, e_so | v};
        if (rc) {cr, cv} = {r[31], !r[31] && r != 0, r == 0, e_so, !dz};
        @(negedge aclk);
        `CHK({ca, ov, so}, {1'b1, e_ov, e_so})
        if (cv) `CHK({lt, gt, eq, cs}, cr)
    endtask : run
    // Hang guard, far beyond some forty ops of under forty cycles
    initial begin
        #250000;
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK({irq, ca, ov, so, lt, gt, eq, cs}, 8'h0)
        axw(UDD_EXC_OFS, 32'h1, UDD_RESP_OKAY);
        axr(UDD_EXC_OFS, 32'h7, 32'h1, UDD_RESP_OKAY);
        axr(8'h10, 32'hffffffff, 32'h0, UDD_RESP_SLVERR);
        axw(8'h10, 32'h7, UDD_RESP_SLVERR);
        // Overflow edges and the signed view of an unsigned quotient
        run(UDD_XO_DOZ, 1'b1, 1'b1, 32'h80000000, 32'h1);
        run(UDD_XO_DOZ, 1'b1, 1'b1, 32'h7fffffff, 32'h80000000);
        run(UDD_XO_DOZ, 1'b0, 1'b1, 32'h1, 32'h1);
        run(UDD_XO_DIVU, 1'b1, 1'b1, 32'hffffffff, 32'h1);
        run(UDD_XO_DIVU, 1'b0, 1'b1, 32'h80000000, 32'h2);
        for (int i = 0; i < 32; i++) begin
            rs = nxt(rs);
            a = rs;
            rs = nxt(rs);
            run(i[0] ? UDD_XO_DIVU : UDD_XO_DOZ, i[1], i[2], a,
                rs >> (8 * i[4:3]));
        end
        // Unknown extended code: taken, dropped, flagged in status
        @(posedge aclk);
        go <= 1'b1;
        req <= {UDD_PRIMARY_OP, 26'h0, 64'h0};
        @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK({wbv, ir}, 2'h1)
        axr(UDD_ISTS_OFS, 32'h4, 32'h4, UDD_RESP_OKAY);
        // Interrupt masked, then enabled, then cleared by the read
        axr(UDD_ISTS_OFS, 32'h0, 32'h0, UDD_RESP_OKAY);
        run(UDD_XO_DIVU, 1'b1, 1'b0, 32'h5, 32'h0);
        `CHK(irq, 1'b0)
        axw(UDD_IMASK_OFS, 32'h2, UDD_RESP_OKAY);
        @(negedge aclk);
        `CHK(irq, 1'b1)
        axr(UDD_ISTS_OFS, 32'hf, 32'hb, UDD_RESP_OKAY);
        @(negedge aclk);
        `CHK(irq, 1'b0)
        stop_test();
    end
endmodule : test_unsigned_divide_and_difference_unit
`default_nettype wire
